//--- sim/analog_core_model.sv
// behavioural model of the analog comparator core beside the control block
`timescale 1ns/1ps
`default_nettype none
module analog_core_model #(
  parameter int BANDGAP_MV = 1000,
  parameter int STEP_MV    = 100
) (
  input  wire logic        i_power_down,
  input  wire logic        i_pos_bandgap,
  input  wire logic        i_neg_mux,
  input  wire logic [2:0]  i_channel,
  input  wire logic [15:0] i_pos_mv,
  input  wire logic [15:0] i_neg_mv,
  output var  logic        o_raw
);
  int pos_v;
  int neg_v;
  // input selection; converter channel k sits at k steps above ground
  always_comb begin
    pos_v = i_pos_bandgap ? BANDGAP_MV : int'(i_pos_mv);
    neg_v = i_neg_mux ? STEP_MV * int'(i_channel) : int'(i_neg_mv);
  end
  // an unpowered core has no defined output, low is the stand-in here
  assign o_raw = i_power_down ? 1'b0 : (pos_v > neg_v);
endmodule : analog_core_model
`default_nettype wire

//--- sim/tb.sv
// self-checking testbench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, vec_ack;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, raw;
  logic        pdown, pos_bg, neg_mux, cap_trig, cap_rout, irq_req, irq;
  logic [2:0]  chan;
  logic [15:0] pos_mv, neg_mv;
  int          fails, checked;
  logic        exp_rise [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  logic        exp_fall [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  cmp_ctrl #(.ADDR_W(8)) uut (.I_CLK_SYS(clk), .I_RSTN(rst_n), .I_AWADDR(awaddr),
    .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
    .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .I_CMP_RAW(raw), .O_CMP_POWER_DOWN(pdown), .O_POS_SEL_BANDGAP(pos_bg),
    .O_NEG_SEL_MUX(neg_mux), .O_NEG_CHANNEL(chan), .O_CAPTURE_TRIGGER(cap_trig),
    .O_CAPTURE_ROUTED(cap_rout), .I_VECTOR_ACK(vec_ack), .O_CMP_IRQ_REQ(irq_req),
    .O_IRQ(irq));
  analog_core_model core (.i_power_down(pdown), .i_pos_bandgap(pos_bg),
    .i_neg_mux(neg_mux), .i_channel(chan), .i_pos_mv(pos_mv), .i_neg_mv(neg_mv),
    .o_raw(raw));

  // ****************************************
  // clock, verdict and bus helpers
  // ****************************************
  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_of_test();
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= v;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // no cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(er));
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    chk("rresp", 32'(rresp), 32'(er));
  endtask : axi_read

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_write(a, v, cmp_ctrl_pkg::RESP_OKAY);
  endtask : wr

  task automatic rd_ctrl(output logic [31:0] v);
    axi_read(cmp_ctrl_pkg::OFS_CTRL_STATUS, v, cmp_ctrl_pkg::RESP_OKAY);
  endtask : rd_ctrl

  task automatic set_v(input logic [15:0] p, input logic [15:0] n);
    @(posedge clk);
    pos_mv <= p;
    neg_mv <= n;
  endtask : set_v

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, vec_ack} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb  = 4'hf;
    pos_mv = 16'h0064;
    neg_mv = 16'h01f4;
    fails = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd_ctrl(d);
    chk("ctrl reset", d, 32'h0);
    // capture route and synchroniser delay
    wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'h04);
    wait_clk(3);
    chk("routed", 32'(cap_rout), 32'h1);
    set_v(16'd600, 16'd500);
    @(posedge clk);
    chk("trigger early", 32'(cap_trig), 32'h0);
    wait_clk(3);
    // timer side keeps its own capture enable; only the trigger is seen here
    chk("trigger", 32'(cap_trig), 32'h1);
    rd_ctrl(d);
    // reset edge field is toggle, so the rise also sets the flag
    chk("ctrl result", d, 32'h34);
    wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'h00);
    wait_clk(3);
    chk("unrouted", 32'({cap_rout, cap_trig}), 32'h0);
    // bandgap replaces a low positive pin
    set_v(16'd100, 16'd500);
    wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'h40);
    wait_clk(4);
    chk("pos sel", 32'(pos_bg), 32'h1);
    rd_ctrl(d);
    chk("bandgap result", d, 32'h70);
    wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'h00);
    wait_clk(4);
    rd_ctrl(d);
    chk("pin result", d, 32'h10);
    // every converter channel as negative input
    set_v(16'd350, 16'd5000);
    wr(cmp_ctrl_pkg::OFS_SPECIAL_FN, 32'h08);
    for (int k = 0; k < 8; k++) begin
      wr(cmp_ctrl_pkg::OFS_CONV_MUX, 32'(k));
      wait_clk(4);
      chk("channel", 32'(chan), 32'(k));
      chk("neg mux", 32'(neg_mux), 32'h1);
      rd_ctrl(d);
      chk("chan result", 32'(d[5]), 32'(350 > 100 * k));
    end
    // a running converter hands the negative input back to the pin
    wr(cmp_ctrl_pkg::OFS_CONV_MUX, 32'h0);
    wr(cmp_ctrl_pkg::OFS_CONV_CTRL, 32'h80);
    wait_clk(4);
    chk("neg pin", 32'(neg_mux), 32'h0);
    rd_ctrl(d);
    chk("pin result", 32'(d[5]), 32'h0);
    wr(cmp_ctrl_pkg::OFS_SPECIAL_FN, 32'h0);
    wr(cmp_ctrl_pkg::OFS_CONV_CTRL, 32'h0);
    // each edge mode against a rise and a fall, enable kept clear
    set_v(16'd100, 16'd500);
    for (int m = 0; m < 4; m++) begin
      wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'(m));
      wait_clk(4);
      wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'h10 | 32'(m));
      set_v(16'd600, 16'd500);
      wait_clk(6);
      rd_ctrl(d);
      chk("flag rise", 32'(d[4]), 32'(exp_rise[m]));
      wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'h10 | 32'(m));
      set_v(16'd100, 16'd500);
      wait_clk(6);
      rd_ctrl(d);
      chk("flag fall", 32'(d[4]), 32'(exp_fall[m]));
    end
    // interrupt request needs flag, enable and global enable
    wr(cmp_ctrl_pkg::OFS_CPU_FLAGS, 32'h80);
    wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'h1b);
    wait_clk(3);
    chk("req idle", 32'(irq_req), 32'h0);
    set_v(16'd600, 16'd500);
    wait_clk(6);
    chk("req set", 32'(irq_req), 32'h1);
    wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'h03);
    wait_clk(3);
    chk("req masked", 32'(irq_req), 32'h0);
    wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'h0b);
    wr(cmp_ctrl_pkg::OFS_CPU_FLAGS, 32'h0);
    wait_clk(3);
    chk("req global", 32'(irq_req), 32'h0);
    wr(cmp_ctrl_pkg::OFS_CPU_FLAGS, 32'h80);
    wait_clk(3);
    chk("req again", 32'(irq_req), 32'h1);
    @(posedge clk);
    vec_ack <= 1'b1;
    @(posedge clk);
    vec_ack <= 1'b0;
    wait_clk(3);
    chk("req acked", 32'(irq_req), 32'h0);
    rd_ctrl(d);
    chk("flag acked", 32'(d[4]), 32'h0);
    // sticky status, enable mask and write-one clear of the level line
    axi_read(cmp_ctrl_pkg::OFS_IRQ_STATUS, d, cmp_ctrl_pkg::RESP_OKAY);
    chk("status", d & 32'h1, 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    wr(cmp_ctrl_pkg::OFS_IRQ_ENABLE, 32'h1);
    wait_clk(3);
    chk("irq", 32'(irq), 32'h1);
    wr(cmp_ctrl_pkg::OFS_IRQ_CLEAR, 32'h1);
    wait_clk(3);
    chk("irq cleared", 32'(irq), 32'h0);
    axi_read(cmp_ctrl_pkg::OFS_IRQ_CLEAR, d, cmp_ctrl_pkg::RESP_OKAY);
    chk("clear reads", d, 32'h0);
    // power off with the interrupt enable clear
    wr(cmp_ctrl_pkg::OFS_CTRL_STATUS, 32'h83);
    wait_clk(3);
    chk("power down", 32'(pdown), 32'h1);
    rd_ctrl(d);
    chk("off bit", 32'(d[7]), 32'h1);
    // unmapped place answers with an error
    axi_write(8'h20, 32'h1, cmp_ctrl_pkg::RESP_SLVERR);
    axi_read(8'h20, d, cmp_ctrl_pkg::RESP_SLVERR);
    chk("unmapped", d, 32'h0);
    end_of_test();
  end
endmodule : tb
`default_nettype wire

//--- verilog/cmp_ctrl.sv
// comparator control logic with an axi4-lite register slave
// How it works
// - result high when positive input exceeds negative
// - result passes a two-flop synchroniser first
// - off bit removes comparator power
// - bandgap bit picks reference for positive input
// - mux feeds negative input when mux bit set and converter off
// - flag set on selected output event
// - flag cleared by vector or writing one
// - request needs flag, enable and global enable
// - capture bit routes output to timer capture
// - edge field picks toggle, fall or rise
// - channel field picks converter input zero to seven
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl #(
  parameter int ADDR_W = 8
) (
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RSTN,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_AWVALID,
  output var  logic              O_AWREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  input  wire logic              I_WVALID,
  output var  logic              O_WREADY,
  output var  logic [1:0]        O_BRESP,
  output var  logic              O_BVALID,
  input  wire logic              I_BREADY,
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  input  wire logic              I_ARVALID,
  output var  logic              O_ARREADY,
  output var  logic [31:0]       O_RDATA,
  output var  logic [1:0]        O_RRESP,
  output var  logic              O_RVALID,
  input  wire logic              I_RREADY,
  // analog core
  input  wire logic              I_CMP_RAW,
  output var  logic              O_CMP_POWER_DOWN,
  output var  logic              O_POS_SEL_BANDGAP,
  output var  logic              O_NEG_SEL_MUX,
  output var  logic [2:0]        O_NEG_CHANNEL,
  // timer capture and interrupt controller
  output var  logic              O_CAPTURE_TRIGGER,
  output var  logic              O_CAPTURE_ROUTED,
  input  wire logic              I_VECTOR_ACK,
  output var  logic              O_CMP_IRQ_REQ,
  output var  logic              O_IRQ
);
  // ***************************************************
  // parameter check and declarations
  // ***************************************************
  if (ADDR_W < 5) begin : g_bad_addr
    $error("cmp_ctrl needs at least five address bits");
  end

  localparam int EVENTS = 2;
  logic [7:0]        ctrl_q;      // writable control bits, result and flag excluded
  logic              flag_q;
  logic              negmux_q;
  logic [2:0]        chan_q;
  logic              conv_en_q;
  logic              gie_q;
  logic [EVENTS-1:0] ists_q;
  logic [EVENTS-1:0] ien_q;
  logic              result_sync;
  logic              event_hit;
  logic              prev_res_q;
  logic              aw_hold_q;
  logic              w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_fire;
  logic [7:0]        wr_ofs;
  logic [7:0]        rd_ofs;
  logic [7:0]        wbyte;
  logic [31:0]       rd_val;
  logic              rd_ok;
  logic              wr_ok;
  logic [EVENTS-1:0] ev_vec;

  // ***************************************************
  // comparator result path
  // ***************************************************
  // comparison happens in the analog core; only its level is synchronised
  cmp_sync #(
    .STAGES (cmp_ctrl_pkg::SYNC_STAGES)
  ) u_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RSTN),
    .i_async (I_CMP_RAW),
    .o_sync  (result_sync)
  );

  cmp_edge_detect u_edge (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RSTN),
    .i_level (result_sync),
    .i_mode  (ctrl_q[cmp_ctrl_pkg::BIT_EDGE_HI:cmp_ctrl_pkg::BIT_EDGE_LO]),
    .o_event (event_hit)
  );

  // previous result copy, used for a level-change status event
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      prev_res_q <= 1'b0;
    end else begin
      prev_res_q <= result_sync;
    end
  end

  // ***************************************************
  // axi4-lite write channel
  // ***************************************************
  assign wr_fire = aw_hold_q & w_hold_q & ~O_BVALID;
  assign wr_ofs  = 8'(awaddr_q);
  assign wbyte   = wstrb_q[0] ? wdata_q[7:0] : 8'h00;
  assign wr_ok   = (wr_ofs[1:0] == 2'h0) && (wr_ofs <= cmp_ctrl_pkg::OFS_CPU_FLAGS);

  // address and data accepted in either order, held until the response
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
      O_BVALID  <= 1'b0;
      O_BRESP   <= cmp_ctrl_pkg::RESP_OKAY;
    end else begin
      O_AWREADY <= ~aw_hold_q & ~O_AWREADY & I_AWVALID;
      O_WREADY  <= ~w_hold_q & ~O_WREADY & I_WVALID;
      if (O_AWREADY && I_AWVALID) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= I_AWADDR;
      end
      if (O_WREADY && I_WVALID) begin
        w_hold_q <= 1'b1;
        wdata_q  <= I_WDATA;
        wstrb_q  <= I_WSTRB;
      end
      if (wr_fire) begin
        O_BVALID  <= 1'b1;
        O_BRESP   <= wr_ok ? cmp_ctrl_pkg::RESP_OKAY : cmp_ctrl_pkg::RESP_SLVERR;
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
      end else if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end

  // ***************************************************
  // control registers
  // ***************************************************
  // only the low byte lane carries the 8-bit registers
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ctrl_q <= cmp_ctrl_pkg::RST_CTRL;
    end else if (wr_fire && wstrb_q[0] && wr_ofs == cmp_ctrl_pkg::OFS_CTRL_STATUS) begin
      ctrl_q <= wbyte & 8'hcf;  // result and flag bits are not stored here
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      negmux_q  <= 1'b0;
      chan_q    <= 3'h0;
      conv_en_q <= 1'b0;
      gie_q     <= 1'b0;
    end else if (wr_fire && wstrb_q[0]) begin
      if (wr_ofs == cmp_ctrl_pkg::OFS_SPECIAL_FN) negmux_q <= wbyte[cmp_ctrl_pkg::BIT_NEG_MUX];
      if (wr_ofs == cmp_ctrl_pkg::OFS_CONV_MUX) chan_q <= wbyte[cmp_ctrl_pkg::CHAN_W-1:0];
      if (wr_ofs == cmp_ctrl_pkg::OFS_CONV_CTRL) conv_en_q <= wbyte[cmp_ctrl_pkg::BIT_CONV_EN];
      if (wr_ofs == cmp_ctrl_pkg::OFS_CPU_FLAGS) gie_q <= wbyte[cmp_ctrl_pkg::BIT_GLOBAL_I];
    end
  end

  // comparator flag: set beats both clears
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      flag_q <= 1'b0;
    end else if (event_hit) begin
      flag_q <= 1'b1;
    end else if (I_VECTOR_ACK) begin
      flag_q <= 1'b0;
    end else if (wr_fire && wstrb_q[0] && wr_ofs == cmp_ctrl_pkg::OFS_CTRL_STATUS
                 && wbyte[cmp_ctrl_pkg::BIT_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  // ***************************************************
  // block status interrupt: flag event and result change
  // ***************************************************
  assign ev_vec = {result_sync ^ prev_res_q, event_hit};

  // write-one-to-clear; a new event in the same cycle survives
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ists_q <= '0;
      ien_q  <= '0;
    end else begin
      if (wr_fire && wstrb_q[0] && wr_ofs == cmp_ctrl_pkg::OFS_IRQ_CLEAR) begin
        ists_q <= (ists_q & ~wbyte[EVENTS-1:0]) | ev_vec;
      end else begin
        ists_q <= ists_q | ev_vec;
      end
      if (wr_fire && wstrb_q[0] && wr_ofs == cmp_ctrl_pkg::OFS_IRQ_ENABLE) begin
        ien_q <= wbyte[EVENTS-1:0];
      end
    end
  end

  // ***************************************************
  // outputs to analog core, timer and cpu
  // ***************************************************
  // registered so every port comes from a flop; one cycle behind the bits
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_CMP_POWER_DOWN  <= 1'b0;
      O_POS_SEL_BANDGAP <= 1'b0;
      O_NEG_SEL_MUX     <= 1'b0;
      O_NEG_CHANNEL     <= 3'h0;
      O_CAPTURE_ROUTED  <= 1'b0;
      O_CAPTURE_TRIGGER <= 1'b0;
      O_CMP_IRQ_REQ     <= 1'b0;
      O_IRQ             <= 1'b0;
    end else begin
      O_CMP_POWER_DOWN  <= ctrl_q[cmp_ctrl_pkg::BIT_OFF];
      O_POS_SEL_BANDGAP <= ctrl_q[cmp_ctrl_pkg::BIT_BANDGAP];
      O_NEG_SEL_MUX     <= negmux_q & ~conv_en_q;
      O_NEG_CHANNEL     <= chan_q;
      O_CAPTURE_ROUTED  <= ctrl_q[cmp_ctrl_pkg::BIT_CAPTURE];
      // timer still needs its own capture enable to interrupt
      O_CAPTURE_TRIGGER <= ctrl_q[cmp_ctrl_pkg::BIT_CAPTURE] & result_sync;
      O_CMP_IRQ_REQ     <= flag_q & ctrl_q[cmp_ctrl_pkg::BIT_IRQ_EN] & gie_q;
      O_IRQ             <= |(ists_q & ien_q);
    end
  end

  // ***************************************************
  // axi4-lite read channel
  // ***************************************************
  assign rd_ofs = 8'(I_ARADDR);
  assign rd_ok  = (rd_ofs[1:0] == 2'h0) && (rd_ofs <= cmp_ctrl_pkg::OFS_CPU_FLAGS);

  // read mux; clear register reads as zero
  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (rd_ofs)
      cmp_ctrl_pkg::OFS_CTRL_STATUS: begin
        rd_val[7:0] = ctrl_q;
        rd_val[cmp_ctrl_pkg::BIT_RESULT] = result_sync;
        rd_val[cmp_ctrl_pkg::BIT_FLAG]   = flag_q;
      end
      cmp_ctrl_pkg::OFS_SPECIAL_FN: rd_val[cmp_ctrl_pkg::BIT_NEG_MUX] = negmux_q;
      cmp_ctrl_pkg::OFS_CONV_MUX:   rd_val[2:0] = chan_q;
      cmp_ctrl_pkg::OFS_CONV_CTRL:  rd_val[cmp_ctrl_pkg::BIT_CONV_EN] = conv_en_q;
      cmp_ctrl_pkg::OFS_IRQ_STATUS: rd_val[EVENTS-1:0] = ists_q;
      cmp_ctrl_pkg::OFS_IRQ_ENABLE: rd_val[EVENTS-1:0] = ien_q;
      cmp_ctrl_pkg::OFS_CPU_FLAGS:  rd_val[cmp_ctrl_pkg::BIT_GLOBAL_I] = gie_q;
      default:                      rd_val = 32'h0000_0000;
    endcase
  end

  // one read at a time; arready pulses, data one cycle later
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      O_ARREADY <= 1'b0;
      O_RVALID  <= 1'b0;
      O_RDATA   <= 32'h0000_0000;
      O_RRESP   <= cmp_ctrl_pkg::RESP_OKAY;
    end else begin
      O_ARREADY <= ~O_ARREADY & ~O_RVALID & I_ARVALID;
      if (O_ARREADY && I_ARVALID) begin
        O_RVALID <= 1'b1;
        O_RDATA  <= rd_val;
        O_RRESP  <= rd_ok ? cmp_ctrl_pkg::RESP_OKAY : cmp_ctrl_pkg::RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  sequence s_event_seen;
    event_hit;
  endsequence

  chk_flag_sets: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    s_event_seen |=> flag_q)
    else $error("flag not set after event");
  chk_reserved_quiet: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    (ctrl_q[1:0] == cmp_ctrl_pkg::EDGE_RESERVED) |-> !event_hit)
    else $error("reserved edge code fired");
  chk_rise_edge: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    (ctrl_q[1:0] == cmp_ctrl_pkg::EDGE_RISE && $rose(result_sync)) |-> event_hit)
    else $error("rising edge missed");
  chk_fall_edge: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    (ctrl_q[1:0] == cmp_ctrl_pkg::EDGE_FALL && !$fell(result_sync)) |-> !event_hit)
    else $error("false falling edge");
  chk_vector_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    (I_VECTOR_ACK && !event_hit) |=> !flag_q)
    else $error("vector did not clear flag");
  chk_irq_request: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    O_CMP_IRQ_REQ |-> $past(flag_q) && $past(gie_q) && $past(ctrl_q[3]))
    else $error("irq request without cause");
  chk_sync_delay: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    $rose(I_CMP_RAW) ##1 I_CMP_RAW |-> ##[0:1] result_sync)
    else $error("result later than two cycles");
  chk_neg_mux: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    ##1 O_NEG_SEL_MUX == ($past(negmux_q) && !$past(conv_en_q)))
    else $error("negative input select wrong");
  chk_power_off: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    ##1 O_CMP_POWER_DOWN == $past(ctrl_q[7]))
    else $error("power-down not following bit");
  // converse of the request check: a full cause must raise the request
  chk_req_raised: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    ($past(flag_q) && $past(gie_q) && $past(ctrl_q[cmp_ctrl_pkg::BIT_IRQ_EN]))
    |-> O_CMP_IRQ_REQ)
    else $error("irq request missing");
  chk_flag_w1c: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    (wr_fire && wstrb_q[0] && wr_ofs == cmp_ctrl_pkg::OFS_CTRL_STATUS
     && wbyte[cmp_ctrl_pkg::BIT_FLAG] && !event_hit) |=> !flag_q)
    else $error("write one did not clear flag");
  chk_bandgap_sel: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    ##1 O_POS_SEL_BANDGAP == $past(ctrl_q[cmp_ctrl_pkg::BIT_BANDGAP]))
    else $error("positive input select wrong");
  chk_capture_route: assert property (@(posedge I_CLK_SYS) disable iff (!I_RSTN)
    ##1 O_CAPTURE_ROUTED == $past(ctrl_q[cmp_ctrl_pkg::BIT_CAPTURE]))
    else $error("capture route not following bit");
endmodule : cmp_ctrl
`default_nettype wire

//--- verilog/cmp_ctrl_pkg.sv
// shared constants for the comparator control block
package cmp_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFS_SPECIAL_FN  = 8'h04;
  localparam logic [7:0] OFS_CONV_MUX    = 8'h08;
  localparam logic [7:0] OFS_CONV_CTRL   = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR   = 8'h18;
  localparam logic [7:0] OFS_CPU_FLAGS   = 8'h1c;
  // control/status bit positions
  localparam int BIT_OFF      = 7;
  localparam int BIT_BANDGAP  = 6;
  localparam int BIT_RESULT   = 5;
  localparam int BIT_FLAG     = 4;
  localparam int BIT_IRQ_EN   = 3;
  localparam int BIT_CAPTURE  = 2;
  localparam int BIT_EDGE_HI  = 1;
  localparam int BIT_EDGE_LO  = 0;
  // other fields
  localparam int BIT_NEG_MUX  = 3;
  localparam int BIT_CONV_EN  = 7;
  localparam int BIT_GLOBAL_I = 7;
  localparam int CHAN_W       = 3;
  // edge select codes
  localparam logic [1:0] EDGE_TOGGLE   = 2'h0;
  localparam logic [1:0] EDGE_RESERVED = 2'h1;
  localparam logic [1:0] EDGE_FALL     = 2'h2;
  localparam logic [1:0] EDGE_RISE     = 2'h3;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_REG  = 8'h00;
  // synchroniser stages, giving 1-2 cycles of delay
  localparam int SYNC_STAGES = 2;
  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cmp_ctrl_pkg

//--- verilog/cmp_edge_detect.sv
// edge detector choosing toggle, fall or rise events
`timescale 1ns/1ps
`default_nettype none
module cmp_edge_detect (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_level,
  input  wire logic [1:0] i_mode,
  output var  logic       o_event
);
  logic prev_q;

  // previous-cycle copy of the synchronised output
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= i_level;
    end
  end

  // event decode; reserved code never fires
  always_comb begin
    unique case (i_mode)
      cmp_ctrl_pkg::EDGE_TOGGLE:   o_event = i_level ^ prev_q;
      cmp_ctrl_pkg::EDGE_RESERVED: o_event = 1'b0;
      cmp_ctrl_pkg::EDGE_FALL:     o_event = prev_q & ~i_level;
      cmp_ctrl_pkg::EDGE_RISE:     o_event = i_level & ~prev_q;
    endcase
  end
endmodule : cmp_edge_detect
`default_nettype wire

//--- verilog/cmp_sync.sv
// two-flop synchroniser for the raw comparator output
`timescale 1ns/1ps
`default_nettype none
module cmp_sync #(
  parameter int STAGES = 2
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_async,
  output var  logic o_sync
);
  logic [STAGES-1:0] chain_q;

  // elaboration check
  if (STAGES < 2) begin : g_bad
    $error("cmp_sync needs at least two stages");
  end

  // first flop feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chain_q <= '0;
    end else begin
      chain_q <= {chain_q[STAGES-2:0], i_async};
    end
  end

  assign o_sync = chain_q[STAGES-1];
endmodule : cmp_sync
`default_nettype wire
